// ==== logic/peer_link_defines.vh ====
// register indices, reset values, frame type codes, scale limits and timing counts for the peer link block
// assumes a 25 MHz system clock
`ifndef PEER_LINK_DEFINES_VH
`define PEER_LINK_DEFINES_VH

`define REG_PEER_LINK_ENABLE      4'h0
`define REG_SLAVE_EXCHANGE        4'h2
`define REG_FRAME_TYPE_SELECT     4'h3
`define REG_TORQUE_RX_OFFSET      4'h4
`define REG_TORQUE_RX_GAIN        4'h5
`define REG_LINK_LOSS_TIMEOUT     4'h6
`define REG_MASTER_SEND_PERIOD    4'h7
`define REG_FREQ_RX_OFFSET        4'h8
`define REG_FREQ_RX_GAIN          4'h9
`define REG_FOLLOW_FREQ_WINDOW    4'hb
`define REG_ROLE_CTRL             4'hc
`define REG_LINK_STATUS           4'hd
`define REG_TORQUE_USED           4'he
`define REG_FREQ_USED             4'hf

`define RST_ENABLE                16'h0000
`define RST_EXCHANGE              16'h0003
`define RST_FRAME_TYPE            16'h0000
`define RST_OFFSET                16'h0000
`define RST_GAIN                  16'h0064
`define RST_TIMEOUT               16'h000a
`define RST_PERIOD                16'h0001
`define RST_WINDOW                16'h0032

`define FRAME_MASTER_SLAVE        1'b0
`define FRAME_DROOP               1'b1

`define GAIN_ONE                  100
`define PCT_MAX                   10000

`define CLK_HZ                    25000000
`define MS_TIME_MS                1
`define MS_CYCLES                 (`CLK_HZ / 1000 * `MS_TIME_MS)
`define TENTH_S_TIME_MS           100
`define TENTH_S_CYCLES            (`CLK_HZ / 1000 * `TENTH_S_TIME_MS)

`endif

// ==== logic/peer_link.v ====
// peer-to-peer reference sharing between drives: registers, master sender, slave scaler
// assumes a frame transceiver outside that moves rxValid/txStart words at the comm rate
// Contract
// - enable setting turns link on; resets off
// - master sends its own frequency or torque
// - link address assigned automatically when enabled
// - three-digit exchange code: follow, fault, warning
// - frame type selects master-slave or droop
// - torque used equals gain times datum plus offset
// - scaled values clamped to plus minus 100%
// - frequency scaled with its own gain/offset
// - link fault after detection time; zero disables
// - master sends every send period, 1ms steps
// - frequency window only in master-slave mode
// - bit rate comes from general comm setting
//
// Chosen here: the register addresses and the address-and-strobe port.
`include "peer_link_defines.vh"
`default_nettype none

module peer_link #(
  parameter MS_CYCLES      = `MS_CYCLES,
  parameter TENTH_S_CYCLES = `TENTH_S_CYCLES,
  parameter [7:0] NODE_SEED = 8'h5a
)(
  input  wire        clk,
  input  wire        rst_n,
  input  wire [3:0]  regAddr,
  input  wire [15:0] regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [15:0] regRdata,
  input  wire [15:0] generalCommRateSetting,
  input  wire signed [15:0] ownFreqRef,
  input  wire signed [15:0] ownTorqueRef,
  input  wire        rxValid,
  input  wire        rxFrameType,
  input  wire signed [15:0] rxFreq,
  input  wire signed [15:0] rxTorque,
  input  wire        rxFault,
  input  wire        rxSlaveOff,
  input  wire        localFault,
  output reg         txStart,
  output reg         txFrameType,
  output reg  [15:0] txData,
  output reg         txFault,
  output reg  [7:0]  linkAddr,
  output reg  [15:0] linkRate,
  output reg         linkEnabled,
  output reg  signed [15:0] torqueUsed,
  output reg  signed [15:0] freqUsed,
  output reg         followValid,
  output reg  [15:0] freqWindow,
  output reg         windowActive,
  output reg         linkFault,
  output reg         slaveOffWarn
);

  // reset release: rst_n takes effect at once, the release
  // reaches the rest of the block two edges later

  reg        rstMeta;
  reg        rstSync;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // software settings, one register per setting

  reg        enable_q;
  reg [15:0] exchange_q;
  reg        frameType_q;
  reg [15:0] tOffset_q;
  reg [15:0] tGain_q;
  reg [15:0] timeout_q;
  reg [15:0] period_q;
  reg [15:0] fOffset_q;
  reg [15:0] fGain_q;
  reg [15:0] window_q;
  reg        isMaster_q;
  reg        sendTorque_q;

  // exchange code digits held as bits: bit0 units, bit1 tens, bit2 hundreds
  wire ignoreMaster = exchange_q[0];
  wire noFaultSend  = exchange_q[1];
  wire warnSlaveOff = exchange_q[2];

  always @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      enable_q     <= 1'b0;
      exchange_q   <= `RST_EXCHANGE;
      frameType_q  <= 1'b0;
      tOffset_q    <= `RST_OFFSET;
      tGain_q      <= `RST_GAIN;
      timeout_q    <= `RST_TIMEOUT;
      period_q     <= `RST_PERIOD;
      fOffset_q    <= `RST_OFFSET;
      fGain_q      <= `RST_GAIN;
      window_q     <= `RST_WINDOW;
      isMaster_q   <= 1'b0;
      sendTorque_q <= 1'b0;
    end
    else if (regWr)
    begin
      case (regAddr)
        `REG_PEER_LINK_ENABLE:   enable_q    <= regWdata[0];
        `REG_SLAVE_EXCHANGE:     exchange_q  <= {13'h0000, regWdata[2:0]};
        `REG_FRAME_TYPE_SELECT:  frameType_q <= regWdata[0];
        `REG_TORQUE_RX_OFFSET:   tOffset_q   <= regWdata;
        `REG_TORQUE_RX_GAIN:     tGain_q     <= regWdata;
        // timeout in tenths of a second, ten seconds at most
        `REG_LINK_LOSS_TIMEOUT:  timeout_q   <= (regWdata > 16'd100) ? 16'd100 : regWdata;
        // send period in ms: 1 ms up to 10 s
        `REG_MASTER_SEND_PERIOD:
        begin
          if (regWdata == 16'h0000)
            period_q <= 16'h0001;
          else if (regWdata > 16'd10000)
            period_q <= 16'd10000;
          else
            period_q <= regWdata;
        end
        `REG_FREQ_RX_OFFSET:     fOffset_q   <= regWdata;
        `REG_FREQ_RX_GAIN:       fGain_q     <= regWdata;
        // window in hundredths of Hz: 0.2 Hz up to 10 Hz
        `REG_FOLLOW_FREQ_WINDOW:
        begin
          if (regWdata < 16'd20)
            window_q <= 16'd20;
          else if (regWdata > 16'd1000)
            window_q <= 16'd1000;
          else
            window_q <= regWdata;
        end
        // bit0 makes this drive the master, bit1 sends torque
        `REG_ROLE_CTRL:
        begin
          isMaster_q   <= regWdata[0];
          sendTorque_q <= regWdata[1];
        end
        default: ;
      endcase
    end
  end

  // scale and clamp: gain in hundredths, values in hundredths of a percent
  function [15:0] scaleClamp;
    input signed [15:0] x;
    input signed [15:0] k;
    input signed [15:0] b;
    reg signed [39:0] acc;
    begin
      acc = ($signed({{24{x[15]}}, x}) * $signed({{24{k[15]}}, k})) / 40'sd100
            + $signed({{24{b[15]}}, b});
      if (acc > 40'sd10000)
        scaleClamp = 16'sd10000;
      else if (acc < -40'sd10000)
        scaleClamp = -16'sd10000;
      else
        scaleClamp = acc[15:0];
    end
  endfunction

  // timebase, sender, supervision and address state

  reg [23:0] msCnt_q;
  reg        msTick_q;
  reg [15:0] sendCnt_q;
  reg [23:0] tenthCnt_q;
  reg [15:0] silentTenths_q;
  reg [7:0]  lfsr_q;
  reg        addrDone_q;
  reg        rxPending_q;

  // frames are taken only by an enabled slave

  wire msWrap    = (msCnt_q == MS_CYCLES - 1);
  wire tenthWrap = (tenthCnt_q == TENTH_S_CYCLES - 1);
  wire rxTake    = enable_q && rxValid && !isMaster_q;

  always @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      msCnt_q        <= 24'h000000;
      msTick_q       <= 1'b0;
      sendCnt_q      <= 16'h0000;
      tenthCnt_q     <= 24'h000000;
      silentTenths_q <= 16'h0000;
      lfsr_q         <= 8'h01;
      addrDone_q     <= 1'b0;
      rxPending_q    <= 1'b0;
      txStart        <= 1'b0;
      txFrameType    <= 1'b0;
      txData         <= 16'h0000;
      txFault        <= 1'b0;
      linkAddr       <= 8'h00;
      linkRate       <= 16'h0000;
      linkEnabled    <= 1'b0;
      torqueUsed     <= 16'h0000;
      freqUsed       <= 16'h0000;
      followValid    <= 1'b0;
      freqWindow     <= 16'h0000;
      windowActive   <= 1'b0;
      linkFault      <= 1'b0;
      slaveOffWarn   <= 1'b0;
    end
    else
    begin
      // status copies of settings and the rate input

      linkEnabled <= enable_q;
      linkRate    <= generalCommRateSetting;
      lfsr_q      <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};

      // address is picked once per enable, no manual setting

      if (!enable_q)
        addrDone_q <= 1'b0;
      else if (!addrDone_q)
      begin
        addrDone_q <= 1'b1;
        // master takes address 1; a slave picks a free-running pseudo-random address
        linkAddr   <= isMaster_q ? 8'h01 : ((lfsr_q ^ NODE_SEED) | 8'h02);
      end

      // millisecond tick for the send period

      msTick_q <= 1'b0;
      if (msWrap)
      begin
        msCnt_q  <= 24'h000000;
        msTick_q <= 1'b1;
      end
      else
        msCnt_q <= msCnt_q + 24'h000001;

      // master sender: one frame per elapsed period
      // the reference is sampled when the frame starts

      txStart <= 1'b0;
      if (!enable_q || !isMaster_q)
        sendCnt_q <= 16'h0000;
      else if (msTick_q)
      begin
        if (sendCnt_q >= period_q - 16'h0001)
        begin
          sendCnt_q   <= 16'h0000;
          txStart     <= 1'b1;
          txFrameType <= frameType_q;
          txData      <= sendTorque_q ? ownTorqueRef : ownFreqRef;
          txFault     <= localFault;
        end
        else
          sendCnt_q <= sendCnt_q + 16'h0001;
      end
      if (!isMaster_q)
        txFault <= localFault && !noFaultSend && enable_q;


      // slave receiver: only frames of the selected type update the used values; any frame can raise slaveOffWarn
      // used values hold until the next accepted frame

      rxPending_q <= rxTake && (rxFrameType == frameType_q);
      if (rxTake && (rxFrameType == frameType_q))
      begin
        torqueUsed <= scaleClamp(rxTorque, tGain_q, tOffset_q);
        freqUsed   <= scaleClamp(rxFreq, fGain_q, fOffset_q);
      end
      followValid <= enable_q && !isMaster_q && !ignoreMaster;
      slaveOffWarn <= enable_q && warnSlaveOff && rxValid && rxSlaveOff;


      // follow window has meaning only with master-slave frames

      windowActive <= enable_q && (frameType_q == `FRAME_MASTER_SLAVE);
      freqWindow   <= (enable_q && (frameType_q == `FRAME_MASTER_SLAVE)) ? window_q
                      : 16'h0000;


      // silence supervision in tenths of a second
      // an accepted frame restarts the count and clears the fault

      if (!enable_q || rxPending_q || (timeout_q == 16'h0000))
      begin
        tenthCnt_q     <= 24'h000000;
        silentTenths_q <= 16'h0000;
        if (!enable_q || timeout_q == 16'h0000)
          linkFault <= 1'b0;
      end
      else if (tenthWrap)
      begin
        tenthCnt_q <= 24'h000000;
        if (silentTenths_q + 16'h0001 >= timeout_q)
          linkFault <= 1'b1;
        else
          silentTenths_q <= silentTenths_q + 16'h0001;
      end
      else
        tenthCnt_q <= tenthCnt_q + 24'h000001;
      if (rxPending_q)
        linkFault <= 1'b0;
      if (rxTake && rxFault && !noFaultSend)
        linkFault <= linkFault;
    end
  end

  // read data stand one cycle after the strobe, zero otherwise

  always @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
      regRdata <= 16'h0000;
    else if (regRd)
    begin
      case (regAddr)
        `REG_PEER_LINK_ENABLE:   regRdata <= {15'h0000, enable_q};
        `REG_SLAVE_EXCHANGE:     regRdata <= exchange_q;
        `REG_FRAME_TYPE_SELECT:  regRdata <= {15'h0000, frameType_q};
        `REG_TORQUE_RX_OFFSET:   regRdata <= tOffset_q;
        `REG_TORQUE_RX_GAIN:     regRdata <= tGain_q;
        `REG_LINK_LOSS_TIMEOUT:  regRdata <= timeout_q;
        `REG_MASTER_SEND_PERIOD: regRdata <= period_q;
        `REG_FREQ_RX_OFFSET:     regRdata <= fOffset_q;
        `REG_FREQ_RX_GAIN:       regRdata <= fGain_q;
        `REG_FOLLOW_FREQ_WINDOW: regRdata <= window_q;
        `REG_ROLE_CTRL:          regRdata <= {14'h0000, sendTorque_q, isMaster_q};
        `REG_LINK_STATUS:        regRdata <= {13'h0000, slaveOffWarn, addrDone_q, linkFault};
        `REG_TORQUE_USED:        regRdata <= torqueUsed;
        `REG_FREQ_USED:          regRdata <= freqUsed;
        default:                 regRdata <= 16'h0000;
      endcase
    end
    else
      regRdata <= 16'h0000;
  end

endmodule

`default_nettype wire

// ==== testbench/peer_link_assertions.sv ====
// port assertions for the peer link block
// bound into every peer_link instance; sees only its ports
`include "peer_link_defines.vh"
`default_nettype none
module peer_link_assertions #(
  parameter MS_CYCLES = 4
)(
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic [15:0]        generalCommRateSetting,
  input wire logic [15:0]        linkRate,
  input wire logic               rxValid,
  input wire logic               txStart,
  input wire logic               linkEnabled,
  input wire logic signed [15:0] torqueUsed,
  input wire logic signed [15:0] freqUsed,
  input wire logic               linkFault
);
  logic [2:0]  up_q;
  logic [15:0] gap_q;
  wire logic   live = up_q == 3'h4;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      up_q <= 3'h0;
      gap_q <= 16'hffff;
    end
    else
    begin
      up_q <= live ? up_q : up_q + 3'h1;
      gap_q <= txStart ? 16'h1 : gap_q + {15'h0, gap_q != 16'hffff};
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence faultGone;
    ##[0:2] !linkFault;
  endsequence
  rate_copy_a:
    assert property (live |-> linkRate == $past(generalCommRateSetting))
    else $error("linkRate lags");
  tx_gap_a:
    assert property (txStart |-> gap_q >= MS_CYCLES)
    else $error("txStart too soon");
  tx_off_a:
    assert property (!linkEnabled [*2] |-> !txStart)
    else $error("txStart while off");
  torque_clamp_a:
    assert property (torqueUsed <= `PCT_MAX && torqueUsed >= -`PCT_MAX)
    else $error("torqueUsed out of range");
  freq_clamp_a:
    assert property (freqUsed <= `PCT_MAX && freqUsed >= -`PCT_MAX)
    else $error("freqUsed out of range");
  used_hold_a:
    assert property (live && linkEnabled && !$past(rxValid) |-> $stable(torqueUsed)
      && $stable(freqUsed))
    else $error("used value moved without a frame");
  fault_off_a:
    assert property ($fell(linkEnabled) |-> faultGone)
    else $error("fault kept after disable");
  fault_rx_a:
    assert property ($rose(linkFault) |-> !$past(rxValid))
    else $error("fault right after a frame");
endmodule
bind peer_link peer_link_assertions #(.MS_CYCLES(MS_CYCLES)) chk_u (.clk, .rst_n,
  .generalCommRateSetting, .linkRate, .rxValid, .txStart, .linkEnabled, .torqueUsed,
  .freqUsed, .linkFault);
`default_nettype wire

// ==== testbench/peer_link_peer.sv ====
// far-side drive handing received frame words to the block
// driven by the bench through task send
`default_nettype none
module peer_link_peer (
  input  wire logic        clk,
  output var  logic        rxValid,
  output var  logic        rxFrameType,
  output var  logic [15:0] rxFreq,
  output var  logic [15:0] rxTorque,
  output var  logic        rxFault,
  output var  logic        rxSlaveOff
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {rxValid, rxFrameType, rxFreq, rxTorque, rxFault, rxSlaveOff} = '0;
  // fields turn to their inverse once the word is gone
  task automatic send(input logic ft, input logic [15:0] t, input logic [15:0] f);
    @(posedge clk);
    rxValid <= 1'b1;
    rxFrameType <= ft;
    rxTorque <= t;
    rxFreq <= f;
    @(posedge clk);
    rxValid <= 1'b0;
    {rxFrameType, rxTorque, rxFreq} <= ~{ft, t, f};
  endtask
endmodule
`default_nettype wire

// ==== testbench/peer_link_tb.sv ====
// self-checking bench for the peer link block
// peer model feeds the receive side; registers go through the plain port
`default_nettype none
module peer_link_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, regWr = 0, regRd = 0, localFault = 0, txOn = 0;
  logic [3:0] regAddr = 0;
  logic [15:0] regWdata = 0, generalCommRateSetting = 0, regRdata, txData, linkRate;
  logic [15:0] freqWindow, lastT = 0, lastF = 0, txExp, rq[$], tq[$], fq[$];
  logic signed [15:0] ownFreqRef = 0, ownTorqueRef = 0, torqueUsed, freqUsed, rxFreq, rxTorque;
  logic rxValid, rxFrameType, rxFault, rxSlaveOff, txStart, txFrameType, txFault;
  logic linkEnabled, followValid, windowActive, linkFault, slaveOffWarn;
  logic [7:0] linkAddr;
  int n_fail = 0, cmp_count = 0, nTx;
  logic [3:0] ra[12] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hb, 4'h1, 4'ha};
  logic [15:0] rv[12] = '{16'h0, 16'h3, 16'h0, 16'h0, 16'h64, 16'ha, 16'h1, 16'h0, 16'h64,
    16'h32, 16'h0, 16'h0};
  logic [3:0] wa[4] = '{4'h2, 4'h7, 4'h6, 4'hb};
  logic [15:0] wd[4] = '{16'hfffc, 16'h0, 16'hc8, 16'h5};
  logic [15:0] we[4] = '{16'h4, 16'h1, 16'h64, 16'h14};
  always #20 clk = ~clk;
  peer_link #(.MS_CYCLES(4), .TENTH_S_CYCLES(20)) dut_u (.clk, .rst_n, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .generalCommRateSetting, .ownFreqRef, .ownTorqueRef, .rxValid,
    .rxFrameType, .rxFreq, .rxTorque, .rxFault, .rxSlaveOff, .localFault, .txStart,
    .txFrameType, .txData, .txFault, .linkAddr, .linkRate, .linkEnabled, .torqueUsed,
    .freqUsed, .followValid, .freqWindow, .windowActive, .linkFault, .slaveOffWarn);
  peer_link_peer peer_u (.clk, .rxValid, .rxFrameType, .rxFreq, .rxTorque, .rxFault,
    .rxSlaveOff);
  task automatic summarize();
    $display("fails %0d compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    rq.push_back(e);
    @(posedge clk);
    regRd <= 1'b0;
  endtask
  function automatic logic [15:0] sc(input int k, input int b, input int x);
    int y;
    y = k * x / 100 + b;
    y = y > 10000 ? 10000 : (y < -10000 ? -10000 : y);
    return y[15:0];
  endfunction
  // ok says whether the block should take the frame
  task automatic frm(input logic ft, input int x, input bit ok);
    lastT = ok ? sc(200, 100, x) : lastT;
    lastF = ok ? sc(50, 0, x) : lastF;
    tq.push_back(lastT);
    fq.push_back(lastF);
    peer_u.send(ft, x[15:0], x[15:0]);
  endtask
  always @(posedge clk)
    if (regRd === 1'b1)
    begin
      #1;
      chk("regRdata", rq.pop_front(), regRdata);
    end
  always @(posedge clk)
    if (rxValid === 1'b1)
    begin
      #1;
      chk("torqueUsed", tq.pop_front(), torqueUsed);
      chk("freqUsed", fq.pop_front(), freqUsed);
    end
  always @(posedge clk)
    if (txStart === 1'b1 && txOn)
    begin
      nTx++;
      chk("txData", txExp, txData);
      chk("txFrameType", 16'h0, {15'h0, txFrameType});
    end
  initial
  begin
    #400000;
    n_fail++;
    summarize();
  end
  initial
  begin
    void'($urandom(32'hcbe22416));
    generalCommRateSetting <= $urandom;
    ownFreqRef <= $urandom;
    ownTorqueRef <= $urandom;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (ra[i]) rd(ra[i], rv[i]);
    foreach (wa[i])
    begin
      wr(wa[i], wd[i]);
      rd(wa[i], we[i]);
    end
    wr(4'h0, 16'h1);
    wr(4'h6, 16'h0);
    wr(4'h5, 16'hc8);
    wr(4'h4, 16'h64);
    wr(4'h9, 16'h32);
    repeat (8) @(posedge clk);
    rd(4'hd, 16'h2);
    chk("linkAddrZero", 16'h0, {15'h0, linkAddr == 8'h00});
    chk("followValid", 16'h1, {15'h0, followValid});
    chk("windowActive", 16'h1, {15'h0, windowActive});
    chk("slaveOffWarn", 16'h0, {15'h0, slaveOffWarn});
    chk("linkEnabled", 16'h1, {15'h0, linkEnabled});
    chk("freqWindow", 16'h14, freqWindow);
    chk("linkRate", generalCommRateSetting, linkRate);
    frm(1'b0, 1000, 1);
    frm(1'b0, 8000, 1);
    frm(1'b0, -8000, 1);
    frm(1'b1, 500, 0);
    repeat (4) frm(1'b0, int'($urandom % 4000) * 2 - 4000, 1);
    wr(4'h3, 16'h1);
    frm(1'b1, 2000, 1);
    frm(1'b0, 3000, 0);
    chk("freqWindow", 16'h0, freqWindow);
    wr(4'h3, 16'h0);
    wr(4'h7, 16'h2);
    for (int r = 1; r < 4; r += 2)
    begin
      wr(4'hc, r[15:0]);
      txExp = r[1] ? ownTorqueRef : ownFreqRef;
      repeat (20) @(posedge clk);
      nTx = 0;
      #1 txOn = 1;
      repeat (80) @(posedge clk);
      #1 txOn = 0;
      chk("txCount", 16'ha, nTx[15:0]);
    end
    wr(4'hc, 16'h0);
    wr(4'h6, 16'h2);
    repeat (10)
    begin
      frm(1'b0, 1000, 1);
      repeat (10) @(posedge clk);
    end
    chk("linkFault", 16'h0, {15'h0, linkFault});
    repeat (80) @(posedge clk);
    chk("linkFault", 16'h1, {15'h0, linkFault});
    wr(4'h6, 16'h0);
    repeat (3) @(posedge clk);
    chk("linkFault", 16'h0, {15'h0, linkFault});
    wr(4'h0, 16'h0);
    frm(1'b0, 3000, 0);
    repeat (4) @(posedge clk);
    chk("linkEnabled", 16'h0, {15'h0, linkEnabled});
    summarize();
  end
endmodule
`default_nettype wire
